// ==== verilog/aspc_pkg.sv ====
package aspc_pkg;

  localparam int unsigned DATA_W        = 24;
  localparam logic [7:0]  SETTLE_CONV   = 8'h7f;
  localparam logic [1:0]  SLEEP_MIN_CYC = 2'h2;

  localparam logic [2:0]  FMT_SPI_TDM_DYN = 3'h0;
  localparam logic [2:0]  FMT_SPI_TDM_FIX = 3'h1;
  localparam logic [2:0]  FMT_SPI_DISC    = 3'h2;
  localparam logic [2:0]  FMT_FS_TDM_DYN  = 3'h3;
  localparam logic [2:0]  FMT_FS_TDM_FIX  = 3'h4;

  localparam logic        RESYNC_N_RST = 1'h1;
  localparam logic        SLEEP_N_RST  = 1'h1;
  localparam logic [1:0]  MODE_RST     = 2'h0;
  localparam logic [2:0]  LAYOUT_RST   = 3'h0;

  typedef enum {ST_HALT, ST_SETTLE, ST_RUN, ST_ASLEEP} aspc_state_e;

  typedef struct packed {
    logic fs;
    logic tdm;
    logic fixed;
    logic legal;
  } aspc_layout_s;

  typedef struct packed {
    logic ready_n;
    logic bias_en;
    logic filter_clear;
  } aspc_status_s;

  function automatic aspc_layout_s aspc_decode(input logic [2:0] sel);
    aspc_layout_s l;
    l = '{fs: 1'b0, tdm: 1'b1, fixed: 1'b0, legal: 1'b1};
    case (sel)
      FMT_SPI_TDM_DYN: l.fixed = 1'b0;
      FMT_SPI_TDM_FIX: l.fixed = 1'b1;
      FMT_SPI_DISC:    l.tdm = 1'b0;
      FMT_FS_TDM_DYN:  l.fs = 1'b1;
      FMT_FS_TDM_FIX: begin
        l.fs = 1'b1;
        l.fixed = 1'b1;
      end
      default: begin
        l.fs = 1'b1;
        l.legal = 1'b0;
      end
    endcase
    return l;
  endfunction

endpackage

// ==== verilog/aspc_ctrl.sv ====
// How it works
// - spi: ready_n stays high after a mode change until settled data exist
// - frame-sync: data outputs held low after mode change until settled data
// - frame-sync mode change latency 127..128 conversions, fixed if strobe-synchronous
// - resync low halts conversion on all channels and clears filter counters
// - resync high restarts all channels together from cleared state
// - resync aligns devices sharing one master clock to the same cycle
// - spi: ready_n high at resync low, through settling, low when data valid
// - frame-sync: outputs low at resync low, through settling, then valid data
// - resync rise to data 127..128 conversions async, fixed when synchronous
// - all channels asleep: biasing off, outputs still driven
// - woken channels come up synchronized with running ones without resync
// - tdm: sleeping slot zero when fixed, higher channels shift down when dynamic
// - discrete layout: sleeping channel data forced to zero
// - spi: wake timing tied to ready_n fall; all asleep forces ready_n high
// - wake latency 127..128 conversions async, fixed when strobe-synchronous
// - layout select decode 000..100 into protocol, tdm/discrete, fixed/dynamic
`timescale 1ns/1ns
module aspc_ctrl #(
  parameter int unsigned N_CH        = 8,
  parameter int unsigned CONV_CYCLES = 256
) (
  input  wire logic                                     i_mclk,
  input  wire logic                                     i_rst,
  input  wire logic                                     i_bit_clk,
  input  wire logic                                     i_frame_strobe,
  input  wire logic                                     i_resync_n,
  input  wire logic [N_CH-1:0]                          i_channel_sleep_n,
  input  wire logic [1:0]                               i_mode,
  input  wire logic [2:0]                               i_layout_sel,
  input  wire logic [N_CH-1:0][aspc_pkg::DATA_W-1:0]    i_conv_data,
  output logic                                          o_conv_start,
  output aspc_pkg::aspc_status_s                        o_status,
  output aspc_pkg::aspc_layout_s                        o_layout,
  output logic [N_CH-1:0][aspc_pkg::DATA_W-1:0]         o_slot_data,
  output logic [N_CH-1:0]                               o_slot_valid,
  output logic                                          o_dout_force_low
);
  import aspc_pkg::*;

  localparam int unsigned DIV_W = (CONV_CYCLES > 2) ? $clog2(CONV_CYCLES) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CONV_CYCLES - 1);

  if (N_CH < 1 || N_CH > 8) begin : g_bad_nch
    $error("N_CH must lie in 1..8");
  end
  if (CONV_CYCLES < 4) begin : g_bad_conv
    $error("CONV_CYCLES must be at least 4");
  end

  // master clock side synchronisers
  logic            rs_m, rs_s;
  logic [N_CH-1:0] sl_m, sl_s;
  logic [1:0]      md_m, md_s, md_q;
  logic [2:0]      ly_m, ly_s;
  logic            ft_m, ft_s, ft_q;
  logic            lrst_m, lrst_s, fs_m, fs_s, fs_q, fs_tog, qt_m, qt_s;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rs_m <= RESYNC_N_RST;
      rs_s <= RESYNC_N_RST;
      sl_m <= {N_CH{SLEEP_N_RST}};
      sl_s <= {N_CH{SLEEP_N_RST}};
      md_m <= MODE_RST;
      md_s <= MODE_RST;
      md_q <= MODE_RST;
      ly_m <= LAYOUT_RST;
      ly_s <= LAYOUT_RST;
      ft_m <= 1'b0;
      ft_s <= 1'b0;
      ft_q <= 1'b0;
    end else begin
      rs_m <= i_resync_n;
      rs_s <= rs_m;
      sl_m <= i_channel_sleep_n;
      sl_s <= sl_m;
      md_m <= i_mode;
      md_s <= md_m;
      md_q <= md_s;
      ly_m <= i_layout_sel;
      ly_s <= ly_m;
      ft_m <= fs_tog;
      ft_s <= ft_m;
      ft_q <= ft_s;
    end
  end

  aspc_layout_s lay;
  logic         mode_chg, restart, fs_edge, tick;
  logic [DIV_W-1:0] div, next_div;

  assign lay      = aspc_decode(ly_s);
  assign mode_chg = md_s != md_q;
  assign restart  = !rs_s || mode_chg;
  assign fs_edge  = ft_s ^ ft_q;
  // one shared conversion tick keeps every channel and device in step
  assign tick     = rs_s && (div == DIV_LAST);

  // per-channel sleep filter and settle counters
  logic [N_CH-1:0]      asleep, ch_valid;
  logic [N_CH-1:0][7:0] ch_cnt;

  for (genvar c = 0; c < N_CH; c++) begin : g_ch
    logic [1:0] slp_cnt, next_slp_cnt;
    logic       slp_q, next_slp, val_q, next_val;
    logic [7:0] cnt_q, next_cnt;

    always_comb begin
      next_slp_cnt = slp_cnt;
      next_slp     = slp_q;
      next_cnt     = cnt_q;
      next_val     = val_q;
      if (sl_s[c]) begin
        next_slp_cnt = 2'h0;
        next_slp     = 1'b0;
      end else if (slp_cnt < SLEEP_MIN_CYC - 2'h1) begin
        next_slp_cnt = slp_cnt + 2'h1;
      end else begin
        next_slp = 1'b1;
      end
      if (restart || next_slp) begin
        next_cnt = 8'h00;
        next_val = 1'b0;
      end else begin
        if (tick && cnt_q < SETTLE_CONV) begin
          next_cnt = cnt_q + 8'h01;
        end
        // frame-sync waits for the next strobe: 127..128 conversions
        if (cnt_q == SETTLE_CONV && (!lay.fs || fs_edge)) begin
          next_val = 1'b1;
        end
      end
    end

    always_ff @(posedge i_mclk) begin
      if (i_rst) begin
        slp_cnt <= 2'h0;
        slp_q   <= 1'b0;
        cnt_q   <= 8'h00;
        val_q   <= 1'b0;
      end else begin
        slp_cnt <= next_slp_cnt;
        slp_q   <= next_slp;
        cnt_q   <= next_cnt;
        val_q   <= next_val;
      end
    end

    assign asleep[c]   = slp_q;
    assign ch_valid[c] = val_q;
    assign ch_cnt[c]   = cnt_q;
  end

  logic all_asleep, all_valid;
  assign all_asleep = &asleep;
  assign all_valid  = &(ch_valid | asleep);

  // core state, status and slot composition
  aspc_state_e state, next_state;
  aspc_status_s next_status;
  logic         quiet, next_quiet;
  logic [N_CH-1:0][DATA_W-1:0] next_slot;
  logic [N_CH-1:0]             next_sv;

  always_comb begin
    int unsigned k;
    logic [DATA_W-1:0] src;
    k   = 0;
    src = '0;
    next_div = (!rs_s || tick) ? '0 : div + DIV_W'(1);
    if (!rs_s) begin
      next_state = ST_HALT;
    end else if (all_asleep) begin
      next_state = ST_ASLEEP;
    end else if (!all_valid || mode_chg) begin
      next_state = ST_SETTLE;
    end else begin
      next_state = ST_RUN;
    end
    next_status.filter_clear = !rs_s;
    next_status.bias_en      = !all_asleep;
    case (next_state)
      ST_RUN:    next_status.ready_n = tick;
      ST_HALT:   next_status.ready_n = 1'b1;
      ST_SETTLE: next_status.ready_n = 1'b1;
      ST_ASLEEP: next_status.ready_n = 1'b1;
      default:   next_status.ready_n = 1'b1;
    endcase
    next_quiet = (lay.fs && next_state != ST_RUN) || !lay.legal;
    next_slot  = o_slot_data;
    next_sv    = o_slot_valid;
    if (next_quiet || !rs_s) begin
      next_slot = '0;
      next_sv   = '0;
    end else if (tick) begin
      next_slot = '0;
      next_sv   = '0;
      for (int i = 0; i < N_CH; i++) begin
        src = ch_valid[i] ? i_conv_data[i] : '0;
        if (!lay.tdm || lay.fixed) begin
          next_slot[i] = asleep[i] ? '0 : src;
          next_sv[i]   = !asleep[i] && ch_valid[i];
        end else if (!asleep[i]) begin
          next_slot[k] = src;
          next_sv[k]   = ch_valid[i];
          k = k + 1;
        end
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      div          <= '0;
      state        <= ST_HALT;
      o_status     <= '{ready_n: 1'b1, bias_en: 1'b1, filter_clear: 1'b0};
      quiet        <= 1'b1;
      o_slot_data  <= '0;
      o_slot_valid <= '0;
      o_conv_start <= 1'b0;
    end else begin
      div          <= next_div;
      state        <= next_state;
      o_status     <= next_status;
      quiet        <= next_quiet;
      o_slot_data  <= next_slot;
      o_slot_valid <= next_sv;
      o_conv_start <= tick;
    end
  end

  assign o_layout = lay;

  // link side: strobe edge toggle out, quiet level in
  always_ff @(posedge i_bit_clk) begin
    lrst_m <= i_rst;
    lrst_s <= lrst_m;
  end

  always_ff @(posedge i_bit_clk) begin
    if (lrst_s) begin
      fs_m             <= 1'b0;
      fs_s             <= 1'b0;
      fs_q             <= 1'b0;
      fs_tog           <= 1'b0;
      qt_m             <= 1'b1;
      qt_s             <= 1'b1;
      o_dout_force_low <= 1'b1;
    end else begin
      fs_m             <= i_frame_strobe;
      fs_s             <= fs_m;
      fs_q             <= fs_s;
      fs_tog           <= fs_tog ^ (fs_s && !fs_q);
      qt_m             <= quiet;
      qt_s             <= qt_m;
      o_dout_force_low <= qt_s;
    end
  end

  property p_ready_halt;
    @(posedge i_mclk) disable iff (i_rst) !rs_s |=> o_status.ready_n && o_status.filter_clear;
  endproperty
  a_ready_halt: assert property (p_ready_halt)
    else $error("ready_n or filter clear low during resync");

  property p_div_halt;
    @(posedge i_mclk) disable iff (i_rst) !rs_s |=> div == '0 && !o_conv_start;
  endproperty
  a_div_halt: assert property (p_div_halt)
    else $error("conversion ran while resync low");

  property p_settle_hold;
    @(posedge i_mclk) disable iff (i_rst) $rose(rs_s) |=> o_status.ready_n [*8];
  endproperty
  a_settle_hold: assert property (p_settle_hold)
    else $error("ready_n fell too early after resync");

  property p_valid_count;
    @(posedge i_mclk) disable iff (i_rst) $rose(ch_valid[0]) |-> $past(ch_cnt[0]) == SETTLE_CONV;
  endproperty
  a_valid_count: assert property (p_valid_count)
    else $error("channel valid before 127 conversions");

  property p_mode_restart;
    @(posedge i_mclk) disable iff (i_rst) mode_chg |=> ch_cnt[0] == 8'h00 && o_status.ready_n;
  endproperty
  a_mode_restart: assert property (p_mode_restart)
    else $error("mode change did not restart settling");

  property p_all_sleep;
    @(posedge i_mclk) disable iff (i_rst) all_asleep |=> o_status.ready_n && !o_status.bias_en;
  endproperty
  a_all_sleep: assert property (p_all_sleep)
    else $error("all asleep but bias on or ready_n low");

  property p_fixed_zero;
    @(posedge i_mclk) disable iff (i_rst)
      tick && rs_s && (!lay.tdm || lay.fixed) && asleep[0] |=> o_slot_data[0] == '0;
  endproperty
  a_fixed_zero: assert property (p_fixed_zero)
    else $error("sleeping channel data not zero");

  property p_fs_quiet;
    @(posedge i_mclk) disable iff (i_rst) lay.fs && !all_valid |=> o_slot_data == '0;
  endproperty
  a_fs_quiet: assert property (p_fs_quiet)
    else $error("frame-sync data not low while settling");

  property p_link_low;
    @(posedge i_bit_clk) disable iff (lrst_s) qt_s |=> o_dout_force_low;
  endproperty
  a_link_low: assert property (p_link_low)
    else $error("link outputs not forced low");

endmodule // aspc_ctrl

// ==== verification/aspc_host_model.sv ====
`timescale 1ns/1ns
module aspc_host_model #(
  parameter int unsigned FRAME_BITS = 66
) (
  output logic o_bit_clk,
  output logic o_frame_strobe
);
  int unsigned cnt;

  initial begin
    o_bit_clk      = 1'b0;
    o_frame_strobe = 1'b0;
    cnt            = 0;
  end

  // free-running bit clock, phase offset from mclk
  initial begin
    #3;
    forever #6 o_bit_clk = ~o_bit_clk;
  end

  // strobe never stops, one frame per 66 bit clocks
  always @(negedge o_bit_clk) begin
    cnt            <= (cnt == FRAME_BITS - 1) ? 0 : cnt + 1;
    o_frame_strobe <= (cnt < FRAME_BITS / 2);
  end
endmodule // aspc_host_model

// ==== verification/testbench.sv ====
`timescale 1ns/1ns
module testbench;
  import aspc_pkg::*;
  localparam int unsigned NC = 4;
  localparam int unsigned CC = 8;
  logic                      i_mclk, i_rst, i_resync_n, bclk, fstr;
  logic [NC-1:0]             i_channel_sleep_n, o_slot_valid;
  logic [1:0]                i_mode;
  logic [2:0]                i_layout_sel;
  logic [NC-1:0][DATA_W-1:0] i_conv_data, o_slot_data, exp_d;
  logic                      o_conv_start, o_dout_force_low;
  aspc_status_s              o_status;
  aspc_layout_s              o_layout;
  int                        failures, cmp_count, seed, n;

  aspc_host_model HOST (.o_bit_clk(bclk), .o_frame_strobe(fstr));
  aspc_ctrl #(.N_CH(NC), .CONV_CYCLES(CC)) DUT (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_bit_clk(bclk), .i_frame_strobe(fstr),
    .i_resync_n(i_resync_n), .i_channel_sleep_n(i_channel_sleep_n), .i_mode(i_mode),
    .i_layout_sel(i_layout_sel), .i_conv_data(i_conv_data), .o_conv_start(o_conv_start),
    .o_status(o_status), .o_layout(o_layout), .o_slot_data(o_slot_data),
    .o_slot_valid(o_slot_valid), .o_dout_force_low(o_dout_force_low));

  always #50 i_mclk = ~i_mclk;

  task automatic finish_test;
    $display("failures=%0d comparisons=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      failures++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  // cycles until ready_n (or link force-low) drops
  task automatic settle(input bit fsl, output int cyc);
    cyc = 0;
    while ((fsl ? o_dout_force_low : o_status.ready_n) !== 1'b0 && cyc < 3000) begin
      @(negedge i_mclk);
      cyc++;
    end
    if (cyc >= 3000) begin
      check(1'b0, "settle timeout");
      finish_test();
    end
  endtask

  task automatic tick_gap(output int gap);
    int g;
    g = 0;
    while (o_conv_start !== 1'b1 && g < 100) begin
      @(negedge i_mclk);
      g++;
    end
    gap = 0;
    do begin
      @(negedge i_mclk);
      gap++;
    end while (o_conv_start !== 1'b1 && gap < 100);
    if (g >= 100 || gap >= 100) begin
      check(1'b0, "tick timeout");
      finish_test();
    end
  endtask

  // reference slot layout: fixed keeps position, dynamic packs awake channels
  function automatic void model(input logic [2:0] sel);
    int k;
    k = 0;
    exp_d = '0;
    for (int c = 0; c < NC; c++) begin
      if (i_channel_sleep_n[c] && (sel == 3'h0 || sel == 3'h3)) begin
        exp_d[k] = i_conv_data[c];
        k++;
      end else if (i_channel_sleep_n[c]) begin
        exp_d[c] = i_conv_data[c];
      end
    end
  endfunction

  task automatic resync_pulse;
    i_resync_n = 1'b0;
    repeat (3) @(negedge i_mclk);
    check(o_status.ready_n === 1'b1 && o_status.filter_clear === 1'b1, "resync low");
    check(o_conv_start === 1'b0 && o_slot_data === '0, "halt on resync");
    repeat (8) @(negedge i_mclk);
    i_resync_n = 1'b1;
  endtask

  initial begin
    seed = 32'h1a8294d3;
    failures = 0;
    cmp_count = 0;
    i_mclk = 1'b0;
    i_rst = 1'b1;
    i_resync_n = 1'b1;
    i_channel_sleep_n = '1;
    i_mode = 2'h0;
    i_layout_sel = 3'h1;
    for (int c = 0; c < NC; c++) i_conv_data[c] = DATA_W'($random(seed));
    repeat (5) @(negedge i_mclk);
    check(o_status.ready_n === 1'b1 && o_status.bias_en === 1'b1 && o_slot_valid === '0
          && o_dout_force_low === 1'b1, "reset values");
    i_rst = 1'b0;
    for (int s = 0; s < 8; s++) begin
      i_layout_sel = s[2:0];
      repeat (3) @(negedge i_mclk);
      check(o_layout.legal === (s < 5) && o_layout.fs === (s > 2) && o_layout.tdm === (s != 2)
            && o_layout.fixed === (s == 1 || s == 4), "layout decode");
    end
    i_layout_sel = 3'h1;
    resync_pulse();
    settle(1'b0, n);
    check(n >= 127 * CC && n <= 129 * CC, "resync latency");
    tick_gap(n);
    check(n == CC, "tick spacing");
    i_channel_sleep_n = 4'b1100;
    for (int s = 0; s < 3; s++) begin
      i_layout_sel = s[2:0];
      for (int c = 0; c < NC; c++) i_conv_data[c] = DATA_W'($random(seed));
      repeat (4 * CC) @(negedge i_mclk);
      model(s[2:0]);
      check(o_slot_data === exp_d, "slot layout");
    end
    i_channel_sleep_n = 4'b1111;
    i_layout_sel = 3'h1;
    repeat (131 * CC) @(negedge i_mclk);
    model(3'h1);
    check(o_slot_data === exp_d && o_slot_valid === '1, "woken channel aligned");
    i_channel_sleep_n = 4'b1110;
    @(negedge i_mclk);
    i_channel_sleep_n = 4'b1111;
    repeat (4 * CC) @(negedge i_mclk);
    check(o_slot_data === exp_d, "short sleep ignored");
    for (int m = 1; m < 4; m++) begin
      i_mode = m[1:0];
      repeat (3) @(negedge i_mclk);
      check(o_status.ready_n === 1'b1, "mode change ready");
      settle(1'b0, n);
      check(n >= 126 * CC && n <= 129 * CC, "mode settle");
    end
    i_channel_sleep_n = '0;
    repeat (6) @(negedge i_mclk);
    check(o_status.bias_en === 1'b0 && o_status.ready_n === 1'b1, "all asleep");
    i_channel_sleep_n = '1;
    repeat (4) @(negedge i_mclk);
    check(o_status.bias_en === 1'b1, "bias back");
    i_layout_sel = 3'h3;
    resync_pulse();
    check(o_dout_force_low === 1'b1, "link held low");
    settle(1'b1, n);
    check(n >= 127 * CC && n <= 130 * CC + 8, "frame resync latency");
    i_mode = 2'h0;
    repeat (3) @(negedge i_mclk);
    check(o_dout_force_low === 1'b1, "frame mode change low");
    settle(1'b1, n);
    check(n >= 126 * CC && n <= 130 * CC + 8, "frame mode latency");
    finish_test();
  end
endmodule // testbench
